//--- ccu_pkg.sv
package ccu_pkg;
    // ----------------------------------------
    // array layout
    // ----------------------------------------
    localparam int NCMP = 13; // crc, four cc, eight cm
    localparam int NCC = 5; // crc plus cc1..cc4, port 1
    localparam int NCM = 8; // shared compare regs, port 4
    localparam int IDX_CRC = 0;
    localparam int IDX_CM0 = 5;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int MC_DIV = 12; // oscillator clocks per machine cycle
    localparam logic [3:0] MC_LAST = 4'(MC_DIV - 1);
    // ----------------------------------------
    // byte offsets of the registers
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_T2 = 8'h04;
    localparam logic [7:0] OFF_CT = 8'h08;
    localparam logic [7:0] OFF_CTREL = 8'h0C;
    localparam logic [7:0] OFF_CMCFG = 8'h10;
    localparam logic [7:0] OFF_PORT = 8'h14;
    localparam logic [7:0] OFF_MATCH = 8'h18;
    localparam logic [7:0] OFF_PMASK = 8'h1C;
    localparam logic [7:0] OFF_STS = 8'h20;
    localparam logic [7:0] OFF_MSK = 8'h24;
    localparam logic [7:0] OFF_CMP = 8'h40; // + 4 * index
    // ----------------------------------------
    // status bit positions
    // ----------------------------------------
    localparam int ST_T2OV = 0;
    localparam int ST_CTOV = 1;
    localparam int ST_EXR = 2;
    localparam int ST_CMP = 3; // 13 bits, one per compare reg
    localparam int ST_SET = 16;
    localparam int ST_CLR = 17;
    localparam int ST_W = 18;
    localparam logic [15:0] ALL_ONES = 16'hFFFF;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {T2_STOP, T2_TIMER, T2_GATED, T2_COUNT} ccu_t2_mode_t;
    typedef enum logic [1:0] {RLD_OFF, RLD_OVF, RLD_EXT, RLD_RSV} ccu_rld_t;
    typedef enum logic {BUS_IDLE, BUS_ACK} ccu_bus_t;
    typedef struct packed {
        logic cm2_en; // port 5 under set/clear match control
        logic [2:0] ct_ps; // compare timer divides by 2 << ct_ps
        logic ct_run;
        ccu_rld_t rld;
        logic t2_ps; // 1: timer 2 counts every second machine cycle in timer and gated modes, counter mode ignores it
        ccu_t2_mode_t t2_mode;
    } ccu_ctrl_t;
    localparam ccu_ctrl_t CTRL_RST = ccu_ctrl_t'(10'h000);
endpackage

//--- ccu_top.sv
// How it works
// - timer mode counts osc/12 or osc/24
// - gated mode counts only while gate high
// - counter mode counts sampled falling edges
// - reload mode 0 reloads on overflow, flags
// - reload mode 1 reloads on trigger fall
// - timer 2 prescaler, reload, overflow request
// - compare timer prescaler, reload, overflow request
// - compare timer free-runs, auto-reloads on overflow
// - compare timer overflow sets its flag
// - timer equals compare value drives pin
// - mode 0: high on match, low on overflow
// - mode 0 ignores software port writes
// - mode 1 shadow latch copied at match
// - mode 2 set match raises masked pins
// - mode 2 clear match lowers masked pins
// - thirteen sixteen-bit compare registers
// - shared regs pick timer and mode
// - crc and cc regs serve timer 2
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
module ccu_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // external timer inputs
    input wire logic timer2_ext_input,
    input wire logic reload_trigger_pin,
    // compare pins
    output logic [4:0] port1_cc_out,
    output logic [7:0] port4_cm_out,
    output logic [7:0] port5_compare_output,
    // interrupt
    output logic irq
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // word decode, used by every register write except the compare array
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    // byte-lane merge for partial writes
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
        wmerge = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                wmerge[8*b +: 8] = nw[8*b +: 8];
            end
        end
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    ccu_pkg::ccu_bus_t bus_q; // bus handshake phase
    logic wait_q; // waitrequest, high when idle
    logic [31:0] rdata_q; // captured read data
    logic [31:0] rd_mux; // read data source
    ccu_pkg::ccu_ctrl_t ctrl_q; // control register
    logic [15:0] t2_q; // timer 2 count
    logic [15:0] ct_q; // compare timer count
    logic [15:0] ct_rel_q; // compare timer reload
    logic [15:0] cmp_q [ccu_pkg::NCMP]; // compare register array
    logic [7:0] cm_en_q; // shared compare enables
    logic [7:0] cm_sel_q; // 1: shared reg on compare timer
    logic [4:0] cc_en_q; // crc/cc compare enables
    logic [4:0] cc_m1_q; // crc/cc in mode 1
    logic [15:0] set_match_reg; // mode 2 set value
    logic [15:0] clear_match_reg; // mode 2 clear value
    logic [7:0] set_pin_mask;
    logic [7:0] clear_pin_mask;
    logic [ccu_pkg::ST_W-1:0] sts_q; // sticky requests
    logic [ccu_pkg::ST_W-1:0] msk_q; // interrupt enables
    logic irq_q;
    logic [ccu_pkg::NCMP-1:0] out_q; // port 1 and port 4 latches
    logic [ccu_pkg::NCMP-1:0] sh_q; // mode 1 shadow latches
    logic [7:0] p5_q; // port 5 latch
    logic [3:0] mc_q; // machine cycle phase
    logic pre_q; // timer 2 divide-by-two
    logic [7:0] div_q; // compare timer prescaler
    logic ext_s1, ext_s2, trg_s1, trg_s2; // synchronisers
    logic ext_mc_q; // count-mode input sample from last machine cycle
    logic trg_prev_q; // previous trigger level
    logic t2_chg_q, ct_chg_q; // timer took a new value

    // bus access strobes
    logic acc_wr, acc_rd;
    assign acc_wr = (bus_q == ccu_pkg::BUS_ACK) && avs_write;
    assign acc_rd = (bus_q == ccu_pkg::BUS_ACK) && avs_read;

    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    // one wait cycle: data is captured, then waitrequest drops for one cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bus_q <= ccu_pkg::BUS_IDLE;
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            case (bus_q)
                ccu_pkg::BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_q <= ccu_pkg::BUS_ACK;
                        wait_q <= 1'b0;
                        rdata_q <= avs_read ? rd_mux : 32'h0000_0000;
                    end
                end
                ccu_pkg::BUS_ACK: begin
                    bus_q <= ccu_pkg::BUS_IDLE;
                    wait_q <= 1'b1;
                end
                default: begin
                    bus_q <= ccu_pkg::BUS_IDLE;
                    wait_q <= 1'b1;
                end
            endcase
        end
    end

    // read mux; unmapped words read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit(avs_address, ccu_pkg::OFF_CTRL)) rd_mux[9:0] = ctrl_q;
        if (hit(avs_address, ccu_pkg::OFF_T2)) rd_mux[15:0] = t2_q;
        if (hit(avs_address, ccu_pkg::OFF_CT)) rd_mux[15:0] = ct_q;
        if (hit(avs_address, ccu_pkg::OFF_CTREL)) rd_mux[15:0] = ct_rel_q;
        if (hit(avs_address, ccu_pkg::OFF_CMCFG)) rd_mux[25:0] = {cc_m1_q, cc_en_q, cm_sel_q, cm_en_q};
        if (hit(avs_address, ccu_pkg::OFF_PORT)) rd_mux[23:0] = {p5_q, out_q[12:5], 3'b000, out_q[4:0]};
        if (hit(avs_address, ccu_pkg::OFF_MATCH)) rd_mux = {clear_match_reg, set_match_reg};
        if (hit(avs_address, ccu_pkg::OFF_PMASK)) rd_mux[15:0] = {clear_pin_mask, set_pin_mask};
        if (hit(avs_address, ccu_pkg::OFF_STS)) rd_mux[ccu_pkg::ST_W-1:0] = sts_q;
        if (hit(avs_address, ccu_pkg::OFF_MSK)) rd_mux[ccu_pkg::ST_W-1:0] = msk_q;
        for (int i = 0; i < ccu_pkg::NCMP; i++) begin
            if (avs_address[7:2] == 6'(ccu_pkg::OFF_CMP[7:2] + 6'(i))) rd_mux[15:0] = cmp_q[i];
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    // control, reload, compare config, match, pin mask and interrupt mask writes
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_q <= ccu_pkg::CTRL_RST;
            ct_rel_q <= 16'h0000;
            {cc_m1_q, cc_en_q, cm_sel_q, cm_en_q} <= 26'h000_0000;
            {clear_match_reg, set_match_reg} <= 32'h0000_0000;
            {clear_pin_mask, set_pin_mask} <= 16'h0000;
            msk_q <= '0;
        end else if (acc_wr) begin
            if (hit(avs_address, ccu_pkg::OFF_CTRL))
                ctrl_q <= ccu_pkg::ccu_ctrl_t'(10'(wmerge(32'(ctrl_q), avs_writedata, avs_byteenable)));
            if (hit(avs_address, ccu_pkg::OFF_CTREL))
                ct_rel_q <= 16'(wmerge({16'h0000, ct_rel_q}, avs_writedata, avs_byteenable));
            if (hit(avs_address, ccu_pkg::OFF_CMCFG))
                {cc_m1_q, cc_en_q, cm_sel_q, cm_en_q} <= 26'(wmerge({6'h00, cc_m1_q, cc_en_q, cm_sel_q, cm_en_q},
                                                                 avs_writedata, avs_byteenable));
            if (hit(avs_address, ccu_pkg::OFF_MATCH))
                {clear_match_reg, set_match_reg} <= wmerge({clear_match_reg, set_match_reg},
                                                           avs_writedata, avs_byteenable);
            if (hit(avs_address, ccu_pkg::OFF_PMASK))
                {clear_pin_mask, set_pin_mask} <= 16'(wmerge({16'h0000, clear_pin_mask, set_pin_mask},
                                                         avs_writedata, avs_byteenable));
            if (hit(avs_address, ccu_pkg::OFF_MSK))
                msk_q <= ccu_pkg::ST_W'(wmerge(32'(msk_q), avs_writedata, avs_byteenable));
        end
    end

    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < ccu_pkg::NCMP; i++) begin
            if (srst) begin
                cmp_q[i] <= 16'h0000;
            end else if (acc_wr && avs_address[7:2] == 6'(ccu_pkg::OFF_CMP[7:2] + 6'(i))) begin
                cmp_q[i] <= 16'(wmerge({16'h0000, cmp_q[i]}, avs_writedata, avs_byteenable));
            end
        end
    end

    // ----------------------------------------
    // input synchronisers and machine cycle
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            {ext_s1, ext_s2, trg_s1, trg_s2} <= 4'h0;
            trg_prev_q <= 1'b0;
        end else begin
            ext_s1 <= timer2_ext_input;
            ext_s2 <= ext_s1;
            trg_s1 <= reload_trigger_pin;
            trg_s2 <= trg_s1;
            trg_prev_q <= trg_s2;
        end
    end

    logic mc_tick, pre_ok, trg_fall;
    assign mc_tick = (mc_q == ccu_pkg::MC_LAST);
    assign pre_ok = !ctrl_q.t2_ps || pre_q;
    assign trg_fall = trg_prev_q && !trg_s2;

    // machine cycle phase, prescaler, once-per-cycle input sample
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mc_q <= 4'h0;
            pre_q <= 1'b0;
            ext_mc_q <= 1'b0;
        end else begin
            mc_q <= mc_tick ? 4'h0 : mc_q + 4'h1;
            if (mc_tick) begin
                pre_q <= !pre_q;
                ext_mc_q <= ext_s2;
            end
        end
    end

    // ----------------------------------------
    // timer 2
    // ----------------------------------------
    logic t2_inc, t2_ovf, t2_wr;
    always_comb begin
        case (ctrl_q.t2_mode)
            ccu_pkg::T2_TIMER: t2_inc = mc_tick && pre_ok;
            ccu_pkg::T2_GATED: t2_inc = mc_tick && pre_ok && ext_s2;
            // two samples span an edge, so at most one count per two cycles
            ccu_pkg::T2_COUNT: t2_inc = mc_tick && ext_mc_q && !ext_s2;
            default: t2_inc = 1'b0;
        endcase
    end
    assign t2_ovf = t2_inc && (t2_q == ccu_pkg::ALL_ONES);
    assign t2_wr = acc_wr && hit(avs_address, ccu_pkg::OFF_T2);

    // software write wins over reload, reload over counting
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            t2_q <= 16'h0000;
            t2_chg_q <= 1'b0;
        end else begin
            t2_chg_q <= t2_wr || t2_inc || (ctrl_q.rld == ccu_pkg::RLD_EXT && trg_fall);
            if (t2_wr) begin
                t2_q <= 16'(wmerge({16'h0000, t2_q}, avs_writedata, avs_byteenable));
            end else if (ctrl_q.rld == ccu_pkg::RLD_EXT && trg_fall) begin
                t2_q <= cmp_q[ccu_pkg::IDX_CRC];
            end else if (t2_ovf && ctrl_q.rld == ccu_pkg::RLD_OVF) begin
                t2_q <= cmp_q[ccu_pkg::IDX_CRC];
            end else if (t2_inc) begin
                t2_q <= t2_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // compare timer
    // ----------------------------------------
    logic ct_tick, ct_ovf, ct_wr;
    logic [8:0] ct_lim;
    assign ct_lim = (9'h002 << ctrl_q.ct_ps) - 9'h001;
    assign ct_tick = ctrl_q.ct_run && ({1'b0, div_q} == ct_lim);
    assign ct_ovf = ct_tick && (ct_q == ccu_pkg::ALL_ONES);
    assign ct_wr = acc_wr && hit(avs_address, ccu_pkg::OFF_CT);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            div_q <= 8'h00;
            ct_q <= 16'h0000;
            ct_chg_q <= 1'b0;
        end else begin
            div_q <= (ct_tick || !ctrl_q.ct_run) ? 8'h00 : div_q + 8'h01;
            ct_chg_q <= ct_tick || ct_wr;
            if (ct_wr) begin
                ct_q <= 16'(wmerge({16'h0000, ct_q}, avs_writedata, avs_byteenable));
            end else if (ct_ovf) begin
                ct_q <= ct_rel_q;
            end else if (ct_tick) begin
                ct_q <= ct_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // match detection
    // ----------------------------------------
    // matches are judged the cycle after the timer moves, so a
    // stopped timer sitting on a compare value fires only once
    logic [ccu_pkg::NCMP-1:0] cmp_match, ch_ovf, ch_en, ch_m1;
    logic set_hit, clr_hit;
    genvar gi;
    for (gi = 0; gi < ccu_pkg::NCMP; gi++) begin : g_ch
        if (gi >= ccu_pkg::IDX_CM0) begin : g_cm
            // shared reg: compare timer means mode 1
            assign cmp_match[gi] = cm_sel_q[gi-ccu_pkg::IDX_CM0] ? (ct_chg_q && ct_q == cmp_q[gi])
                                                                 : (t2_chg_q && t2_q == cmp_q[gi]);
            assign ch_ovf[gi] = cm_sel_q[gi-ccu_pkg::IDX_CM0] ? ct_ovf : t2_ovf;
            assign ch_en[gi] = cm_en_q[gi-ccu_pkg::IDX_CM0];
            assign ch_m1[gi] = cm_sel_q[gi-ccu_pkg::IDX_CM0];
        end else begin : g_cc
            // crc and cc regs fixed to timer 2
            assign cmp_match[gi] = t2_chg_q && t2_q == cmp_q[gi];
            assign ch_ovf[gi] = t2_ovf;
            assign ch_en[gi] = cc_en_q[gi];
            assign ch_m1[gi] = cc_m1_q[gi];
        end
    end
    assign set_hit = t2_chg_q && t2_q == set_match_reg;
    assign clr_hit = t2_chg_q && t2_q == clear_match_reg;

    // ----------------------------------------
    // port latches
    // ----------------------------------------
    logic [ccu_pkg::NCMP-1:0] wr_lat, wr_val;
    logic p_wr;
    assign p_wr = acc_wr && hit(avs_address, ccu_pkg::OFF_PORT);
    assign wr_lat = {{8{p_wr && avs_byteenable[1]}}, {5{p_wr && avs_byteenable[0]}}};
    assign wr_val = {avs_writedata[15:8], avs_writedata[4:0]};

    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < ccu_pkg::NCMP; i++) begin
            if (srst) begin
                out_q[i] <= 1'b1;
                sh_q[i] <= 1'b1;
            end else if (!ch_en[i]) begin
                if (wr_lat[i]) begin
                    out_q[i] <= wr_val[i];
                    sh_q[i] <= wr_val[i];
                end
            end else if (!ch_m1[i]) begin
                // port write dropped in mode 0
                if (cmp_match[i]) out_q[i] <= 1'b1;
                else if (ch_ovf[i]) out_q[i] <= 1'b0;
            end else begin
                if (wr_lat[i]) sh_q[i] <= wr_val[i];
                if (cmp_match[i]) out_q[i] <= sh_q[i];
            end
        end
    end

    // port 5: software latch, or set/clear matches in mode 2
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            p5_q <= 8'hFF;
        end else if (ctrl_q.cm2_en) begin
            // set then clear, clear wins on a tie
            p5_q <= ((p5_q | (set_hit ? set_pin_mask : 8'h00))
                     & ~(clr_hit ? clear_pin_mask : 8'h00));
        end else if (p_wr && avs_byteenable[2]) begin
            p5_q <= avs_writedata[23:16];
        end
    end

    // ----------------------------------------
    // requests and interrupt
    // ----------------------------------------
    logic [ccu_pkg::ST_W-1:0] ev, sts_d;
    // events, set wins over read clear
    assign ev = {clr_hit && ctrl_q.cm2_en, set_hit && ctrl_q.cm2_en, cmp_match,
                 ctrl_q.rld == ccu_pkg::RLD_EXT && trg_fall, ct_ovf, t2_ovf};
    always_comb begin
        sts_d = sts_q;
        if (acc_rd && hit(avs_address, ccu_pkg::OFF_STS)) sts_d = sts_q & ~rdata_q[ccu_pkg::ST_W-1:0];
        sts_d = sts_d | ev;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sts_q <= '0;
            irq_q <= 1'b0;
        end else begin
            sts_q <= sts_d;
            irq_q <= |(sts_d & msk_q);
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign port1_cc_out = out_q[4:0];
    assign port4_cm_out = out_q[12:5];
    assign port5_compare_output = p5_q;
    assign irq = irq_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_timer_rate: assert property (@(posedge sys_clk) disable iff (srst)
        (t2_inc && ctrl_q.t2_mode == ccu_pkg::T2_TIMER) |=> !t2_inc [*8])
        else $error("timer 2 counted faster than one machine cycle");
    chk_gate_stop: assert property (@(posedge sys_clk) disable iff (srst)
        (ctrl_q.t2_mode == ccu_pkg::T2_GATED && !ext_s2) |-> !t2_inc)
        else $error("timer 2 counted with gate low");
    chk_count_rate: assert property (@(posedge sys_clk) disable iff (srst)
        (t2_inc && ctrl_q.t2_mode == ccu_pkg::T2_COUNT) |=> !t2_inc [*8])
        else $error("event counter counted too fast");
    chk_t2_reload: assert property (@(posedge sys_clk) disable iff (srst)
        (t2_ovf && ctrl_q.rld == ccu_pkg::RLD_OVF && !t2_wr && !trg_fall)
        |=> t2_q == $past(cmp_q[ccu_pkg::IDX_CRC]) && sts_q[ccu_pkg::ST_T2OV])
        else $error("timer 2 overflow reload or flag missing");
    chk_ext_reload: assert property (@(posedge sys_clk) disable iff (srst)
        (ctrl_q.rld == ccu_pkg::RLD_EXT && trg_fall && !t2_wr) |=> t2_q == $past(cmp_q[ccu_pkg::IDX_CRC]))
        else $error("trigger reload missing");
    chk_ct_reload: assert property (@(posedge sys_clk) disable iff (srst)
        (ct_ovf && !ct_wr) |=> ct_q == $past(ct_rel_q))
        else $error("compare timer did not reload");
    chk_ct_flag: assert property (@(posedge sys_clk) disable iff (srst)
        ct_ovf |=> sts_q[ccu_pkg::ST_CTOV])
        else $error("compare timer flag not set");
    chk_mode0_set: assert property (@(posedge sys_clk) disable iff (srst)
        (ch_en[ccu_pkg::IDX_CM0] && !ch_m1[ccu_pkg::IDX_CM0] && cmp_match[ccu_pkg::IDX_CM0])
        |=> out_q[ccu_pkg::IDX_CM0] ##1 (out_q[ccu_pkg::IDX_CM0] || $past(ch_ovf[ccu_pkg::IDX_CM0])))
        else $error("mode 0 output not raised on match");
    chk_mode0_hold: assert property (@(posedge sys_clk) disable iff (srst)
        (ch_en[ccu_pkg::IDX_CM0] && !ch_m1[ccu_pkg::IDX_CM0] && wr_lat[ccu_pkg::IDX_CM0]
         && !cmp_match[ccu_pkg::IDX_CM0] && !ch_ovf[ccu_pkg::IDX_CM0]) |=> $stable(out_q[ccu_pkg::IDX_CM0]))
        else $error("mode 0 output followed a port write");
    chk_mode1_copy: assert property (@(posedge sys_clk) disable iff (srst)
        (ch_en[ccu_pkg::IDX_CM0] && ch_m1[ccu_pkg::IDX_CM0] && cmp_match[ccu_pkg::IDX_CM0])
        |=> out_q[ccu_pkg::IDX_CM0] == $past(sh_q[ccu_pkg::IDX_CM0]))
        else $error("mode 1 shadow not copied at match");
    chk_mode2_set: assert property (@(posedge sys_clk) disable iff (srst)
        (ctrl_q.cm2_en && set_hit && !clr_hit) |=> (p5_q & $past(set_pin_mask)) == $past(set_pin_mask))
        else $error("mode 2 set match left a pin low");
    chk_mode2_clr: assert property (@(posedge sys_clk) disable iff (srst)
        (ctrl_q.cm2_en && clr_hit) |=> (p5_q & $past(clear_pin_mask)) == 8'h00)
        else $error("mode 2 clear match left a pin high");
    chk_match_flag: assert property (@(posedge sys_clk) disable iff (srst)
        cmp_match[0] |=> sts_q[ccu_pkg::ST_CMP] ##1 (sts_q[ccu_pkg::ST_CMP] || $past(acc_rd)))
        else $error("match did not set request flag");
endmodule

//--- ccu_pin_model.sv
module ccu_pin_model (
    // clock
    input wire logic sys_clk,
    // scenario controls
    input wire logic ev_run,
    input wire logic gate_lvl,
    input wire logic trig_fall,
    // pins toward the block
    output logic timer2_ext_input,
    output logic reload_trigger_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] div_q = 5'h00; // clocks spent at the present level
    logic ext_q = 1'b1; // starts high, then follows gate_lvl while ev_run is low
    always_ff @(posedge sys_clk) begin
        div_q <= (div_q == 5'h17) ? 5'h00 : div_q + 5'h01;
        if (!ev_run) ext_q <= gate_lvl;
        else if (div_q == 5'h17) ext_q <= ~ext_q;
    end
    assign reload_trigger_pin = ~trig_fall;
    assign timer2_ext_input = ext_q;
endmodule

//--- tb_ccu_top.sv
module tb_ccu_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, srst = 1, avs_read = 0, avs_write = 0, ev_run = 0, gate_lvl = 0, trig_fall = 0;
    logic [7:0] avs_address = 0, port4_cm_out, port5_compare_output;
    logic [31:0] avs_writedata = 0, avs_readdata, q;
    logic [3:0] avs_byteenable = 4'hF;
    logic avs_waitrequest, timer2_ext_input, reload_trigger_pin, irq;
    logic [4:0] port1_cc_out;
    logic [31:0] rv; // random reload value
    int n_errors = 0, checks = 0;
    ccu_top u_ccu_top (.sys_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .timer2_ext_input, .reload_trigger_pin, .port1_cc_out, .port4_cm_out,
        .port5_compare_output, .irq);
    ccu_pin_model u_ccu_pin_model (.sys_clk, .ev_run, .gate_lvl, .trig_fall, .timer2_ext_input, .reload_trigger_pin);
    initial forever #25 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // one access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic clks(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // window check, slack covers sync and bus latency
    function automatic logic [31:0] inr(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
        return 32'(v >= lo && v <= hi);
    endfunction
    task automatic final_report;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        void'($urandom(51));
        rv = 32'($urandom_range(32'h0000_FFF0, 32'h0000_8000));
        clks(6);
        srst <= 0;
        clks(1);
        chk({irq, avs_waitrequest, port1_cc_out, port4_cm_out, port5_compare_output}, 32'h003F_FFFF);
        bus(0, 8'hFC, 0); chk(q, 0); // unmapped word reads zero
        for (int ps = 0; ps < 2; ps++) begin
            bus(1, 8'h04, 0); bus(1, 8'h00, 32'(1 + 4 * ps)); clks(240); bus(1, 8'h00, 0);
            bus(0, 8'h04, 0); chk(inr(q, 19 - 10 * ps, 21 - 10 * ps), 1);
        end
        bus(1, 8'h04, 0); bus(1, 8'h00, 2); clks(120); bus(0, 8'h04, 0); chk(q, 0);
        gate_lvl <= 1; clks(120); gate_lvl <= 0; bus(0, 8'h04, 0); chk(inr(q, 9, 11), 1);
        bus(1, 8'h04, 0); bus(1, 8'h00, 3); ev_run <= 1; clks(480); ev_run <= 0; clks(30);
        bus(0, 8'h04, 0); chk(inr(q, 9, 12), 1);
        bus(1, 8'h00, 0); bus(1, 8'h40, rv); bus(1, 8'h00, 32'h0000_0010); trig_fall <= 1; clks(30);
        trig_fall <= 0; clks(30); bus(0, 8'h04, 0); chk(q, rv);
        bus(0, 8'h20, 0); chk(q[2], 1);
        bus(1, 8'h24, 1); bus(1, 8'h04, 32'h0000_FFFE); bus(1, 8'h00, 32'h0000_0009); clks(36);
        bus(1, 8'h00, 0); chk(irq, 1); bus(0, 8'h04, 0); chk(inr(q, rv, rv + 3), 1);
        bus(0, 8'h20, 0); chk(q[0], 1); clks(3); chk(irq, 0);
        bus(1, 8'h14, 0); bus(1, 8'h54, 32'h0000_0010); bus(1, 8'h10, 1); bus(1, 8'h14, 32'h0000_FF00);
        clks(1); chk(port4_cm_out, 8'hFE); bus(1, 8'h04, 8); bus(1, 8'h00, 1); clks(150);
        chk(port4_cm_out[0], 1); bus(0, 8'h20, 0); chk(q[8], 1);
        bus(1, 8'h04, 32'h0000_FFFE); clks(40); chk(port4_cm_out[0], 0);
        bus(1, 8'h00, 0); bus(1, 8'h1C, 32'h0000_3CF0); bus(1, 8'h18, 32'h0010_0008);
        bus(1, 8'h04, 0); bus(1, 8'h00, 32'h0000_0201); clks(150); chk(port5_compare_output, 8'hF0);
        clks(100); chk(port5_compare_output, 8'hC0);
        bus(1, 8'h00, 0); bus(1, 8'h0C, rv); bus(1, 8'h08, 32'h0000_FFF0); bus(1, 8'h00, 32'h0000_0020);
        clks(40); bus(1, 8'h00, 0); bus(0, 8'h08, 0); chk(inr(q, rv, rv + 10), 1);
        bus(0, 8'h20, 0); chk(q[1], 1);
        chk(port4_cm_out[0], 1);
        // shared channel 0 moved to the compare timer, so mode 1
        bus(1, 8'h10, 32'h0000_0101);
        bus(1, 8'h14, 0);
        clks(1);
        chk(port4_cm_out[0], 1);
        bus(1, 8'h08, 0);
        bus(1, 8'h00, 32'h0000_0020);
        clks(60);
        chk(port4_cm_out[0], 0);
        final_report;
    end
    initial begin
        clks(20000);
        n_errors++;
        final_report;
    end
endmodule
